// >>> lhs_pkg.sv
package lhs_pkg;
	// host bus width and serial framing
	localparam int LHS_DW = 8;
	localparam int LHS_CNT_W = 3;
	localparam logic [2:0] LHS_LAST_BIT = 3'h7;
	localparam int LHS_SER_DI_BIT = 7;
	localparam int LHS_SER_CLK_BIT = 6;
	localparam logic [7:0] LHS_BYTE_RST = 8'h00;
	// synchronised control vector: {par_ser, style, cs_n, cmd_data, rd, wr}
	localparam int LHS_CTL_W = 6;
	localparam logic [5:0] LHS_CTL_RST = 6'h0b;
	localparam int LHS_CTL_PS = 5;
	localparam int LHS_CTL_STYLE = 4;
	localparam int LHS_CTL_CS = 3;
	localparam int LHS_CTL_A0 = 2;
	localparam int LHS_CTL_RD = 1;
	localparam int LHS_CTL_WR = 0;
	// timing: main clock and the host's gap between serial instructions
	localparam int LHS_MCLK_NS = 20;
	localparam int LHS_SER_GAP_NS = 450;
	localparam int LHS_SER_GAP_CYC = (LHS_SER_GAP_NS + LHS_MCLK_NS - 1) / LHS_MCLK_NS;
	// parallel cycle states
	typedef enum logic [1:0] {
		LHS_IDLE = 2'b00,
		LHS_RD = 2'b01,
		LHS_FETCH = 2'b10,
		LHS_WR = 2'b11
	} lhs_state_t;
endpackage

// >>> lhs_ser_if.sv
`timescale 1ns/10ps
interface lhs_ser_if;
	import lhs_pkg::*;
	logic [LHS_DW-1:0] byte_val;
	logic is_data;
	logic tog;
	logic part;
	logic [LHS_DW-1:0] part_val;
	// serial receiver drives, main clock side reads
	modport rx (output byte_val, output is_data, output tog, output part, output part_val);
	modport core (input byte_val, input is_data, input tog, input part, input part_val);
endinterface

// >>> lhs_sync.sv
`timescale 1ns/10ps
module lhs_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// asynchronous level in, synchronised level out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// two flops; the first is read by the second only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= RST;
			q <= RST;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// >>> lhs_ser_rx.sv
`timescale 1ns/10ps
module lhs_ser_rx import lhs_pkg::*; (
	// link clock and resets
	input wire logic ser_clk,
	input wire logic rst_n,
	// raw pins, timed to the serial clock by the host
	input wire logic cs_n,
	input wire logic par_ser,
	input wire logic sdi,
	input wire logic cmd_data,
	// towards the main clock domain
	lhs_ser_if.rx sif
);
	logic [LHS_DW-1:0] shift_reg;
	logic [LHS_CNT_W-1:0] cnt_reg;
	logic part_reg;
	logic [LHS_DW-1:0] byte_reg;
	logic is_data_reg;
	logic tog_reg;
	logic [LHS_DW-1:0] part_val_reg;
	wire logic sh_rst_n;
	wire logic active;
	wire logic last_bit;
	wire logic [LHS_DW-1:0] shift_next;

	// deselect or parallel strap holds shifter and counter in reset
	assign sh_rst_n = rst_n & ~cs_n & ~par_ser;
	assign active = ~cs_n & ~par_ser;
	assign last_bit = (cnt_reg == LHS_LAST_BIT);
	assign shift_next = {shift_reg[LHS_DW-2:0], sdi};

	// shifter and bit counter; counter wraps after the eighth edge
	always_ff @(posedge ser_clk or negedge sh_rst_n) begin
		if (!sh_rst_n) begin
			shift_reg <= LHS_BYTE_RST;
			cnt_reg <= '0;
			part_reg <= 1'b0;
		end else begin
			shift_reg <= shift_next;
			cnt_reg <= cnt_reg + 3'h1;
			part_reg <= ~last_bit;
		end
	end

	// completed byte, its tag and a toggle survive deselection
	always_ff @(posedge ser_clk or negedge rst_n) begin
		if (!rst_n) begin
			byte_reg <= LHS_BYTE_RST;
			is_data_reg <= 1'b0;
			tog_reg <= 1'b0;
			part_val_reg <= LHS_BYTE_RST;
		end else if (active) begin
			part_val_reg <= shift_next;
			if (last_bit) begin
				byte_reg <= shift_next;
				is_data_reg <= cmd_data;
				tog_reg <= ~tog_reg;
			end
		end
	end

	// byte and tag stay put for eight serial clocks after each toggle
	assign sif.byte_val = byte_reg;
	assign sif.is_data = is_data_reg;
	assign sif.tog = tog_reg;
	assign sif.part = part_reg;
	assign sif.part_val = part_val_reg;
endmodule

// >>> lhs_host_if.sv
// How it works
// - eight-bit shifter plus three-bit edge counter
// - serial pins live only when selected, serial strap
// - deselect clears shifter and counter
// - msb first, captured on serial clock rise
// - eighth rise hands byte to internal bus
// - command/data line at eighth rise routes byte
// - cut short byte becomes a bogus instruction
// - serial mode has no read path
// - data reads return bus-holder contents, then refetch
// - written data committed on next data write
// - deselected: data pins float, inputs ignored
// - hardware reset acts regardless of select
// - strap picks parallel bus or serial pins
// - command/data plus strobes decode cycle type
`timescale 1ns/10ps
module lhs_host_if import lhs_pkg::*; #(
	parameter int DW = LHS_DW
) (
	// main clock and hardware reset
	input wire logic MCLK,
	input wire logic RSTN,
	// serial clock, the data bit 6 pin in serial mode
	input wire logic SER_CLK,
	// straps
	input wire logic PAR_SER_SEL,
	input wire logic BUS_STYLE_SELECT,
	// host control pins
	input wire logic CS_N,
	input wire logic CMD_DATA_SELECT,
	input wire logic RD_N,
	input wire logic WR_N,
	// host data pins, split into in, out and enable
	input wire logic [DW-1:0] D_IN,
	output logic [DW-1:0] D_OUT,
	output logic [DW-1:0] D_OE,
	// instruction decoder side
	output logic INSTR_STB,
	output logic [DW-1:0] INSTR_DATA,
	output logic INSTR_ERR,
	// display memory side
	output logic MEM_WE,
	output logic [DW-1:0] MEM_WDATA,
	output logic MEM_RD_REQ,
	input wire logic [DW-1:0] MEM_RDATA,
	input wire logic [DW-1:0] STATUS_IN,
	// serial byte notification
	output logic SER_BYTE_STB,
	output logic SER_BYTE_IS_DATA
);
	lhs_ser_if sif();

	logic [LHS_CTL_W-1:0] ctl_s;
	logic [DW-1:0] dat_s;
	logic tog_s;
	logic part_s;
	lhs_state_t state_reg;
	lhs_state_t state_next;
	logic cyc_a0_reg;
	logic [DW-1:0] wr_data_reg;
	logic [DW-1:0] rd_hold_reg;
	logic [DW-1:0] wr_hold_reg;
	logic wr_hold_vld_reg;
	logic [DW-1:0] dout_reg;
	logic instr_stb_reg;
	logic [DW-1:0] instr_data_reg;
	logic instr_err_reg;
	logic mem_we_reg;
	logic [DW-1:0] mem_wdata_reg;
	logic mem_rd_req_reg;
	logic ser_stb_reg;
	logic ser_is_data_reg;
	logic tog_prev_reg;
	logic part_late_reg;
	logic cs_prev_reg;

	// serial receiver on the link clock
	lhs_ser_rx u_rx (
		.ser_clk(SER_CLK),
		.rst_n(RSTN),
		.cs_n(CS_N),
		.par_ser(PAR_SER_SEL),
		.sdi(D_IN[LHS_SER_DI_BIT]),
		.cmd_data(CMD_DATA_SELECT),
		.sif(sif.rx)
	);

	// host pins are asynchronous to the main clock
	lhs_sync #(.W(LHS_CTL_W), .RST(LHS_CTL_RST)) u_ctl_sync (
		.clk(MCLK),
		.rst_n(RSTN),
		.d({PAR_SER_SEL, BUS_STYLE_SELECT, CS_N, CMD_DATA_SELECT, RD_N, WR_N}),
		.q(ctl_s)
	);

	lhs_sync #(.W(DW), .RST('0)) u_dat_sync (
		.clk(MCLK),
		.rst_n(RSTN),
		.d(D_IN),
		.q(dat_s)
	);

	// toggle and partial-byte level from the link domain
	lhs_sync #(.W(2), .RST(2'h0)) u_ser_sync (
		.clk(MCLK),
		.rst_n(RSTN),
		.d({sif.tog, sif.part}),
		.q({tog_s, part_s})
	);

	// decoded pin levels
	wire logic par_mode = ctl_s[LHS_CTL_PS];
	wire logic style68 = ctl_s[LHS_CTL_STYLE];
	wire logic cs_n_s = ctl_s[LHS_CTL_CS];
	wire logic a0_s = ctl_s[LHS_CTL_A0];
	wire logic rd_pin = ctl_s[LHS_CTL_RD];
	wire logic wr_pin = ctl_s[LHS_CTL_WR];
	wire logic bus_live = par_mode & ~cs_n_s;

	// in the 68 style the read pin is the enable and the write pin is r/w
	wire logic rd_act = bus_live & (style68 ? (rd_pin & wr_pin) : ~rd_pin);
	wire logic wr_act = bus_live & (style68 ? (rd_pin & ~wr_pin) : ~wr_pin);

	// end of a parallel cycle; deselect mid-cycle drops it without effect
	wire logic cyc_abort = ~bus_live;
	wire logic rd_end = (state_reg == LHS_RD) & ~rd_act & ~cyc_abort;
	wire logic wr_end = (state_reg == LHS_WR) & ~wr_act & ~cyc_abort;

	// serial events seen in the main clock domain
	wire logic ser_new = tog_s ^ tog_prev_reg;
	wire logic cs_rise = cs_n_s & ~cs_prev_reg;
	// the partial level lags select by one flop, so it still shows the cut byte
	wire logic ser_cut = cs_rise & part_late_reg & ~par_mode;

	// routing of writes to memory holder or instruction decoder
	wire logic ser_data = ser_new & sif.is_data;
	wire logic ser_instr = ser_new & ~sif.is_data;
	wire logic data_wr_evt = (wr_end & cyc_a0_reg) | ser_data;
	wire logic instr_evt = (wr_end & ~cyc_a0_reg) | ser_instr | ser_cut;
	wire logic [DW-1:0] data_wr_val = ser_new ? sif.byte_val : wr_data_reg;
	wire logic [DW-1:0] instr_val = ser_cut ? sif.part_val : data_wr_val;

	// a data read answers from the holder; a status read from the core
	wire logic [DW-1:0] rd_src = a0_s ? rd_hold_reg : STATUS_IN;

	// parallel cycle sequencing
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			LHS_IDLE: begin
				if (rd_act) begin
					state_next = LHS_RD;
				end else if (wr_act) begin
					state_next = LHS_WR;
				end
			end
			LHS_RD: begin
				if (cyc_abort) begin
					state_next = LHS_IDLE;
				end else if (!rd_act) begin
					state_next = cyc_a0_reg ? LHS_FETCH : LHS_IDLE;
				end
			end
			LHS_FETCH: begin
				state_next = LHS_IDLE;
			end
			LHS_WR: begin
				if (cyc_abort || !wr_act) begin
					state_next = LHS_IDLE;
				end
			end
			default: begin
				state_next = LHS_IDLE;
			end
		endcase
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			state_reg <= LHS_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// cycle type is held while the strobe is active; write data follows the pins until the strobe ends
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			cyc_a0_reg <= 1'b0;
			wr_data_reg <= '0;
			dout_reg <= '0;
		end else begin
			if (state_reg == LHS_IDLE) begin
				cyc_a0_reg <= a0_s;
				dout_reg <= rd_src;
			end
			if (state_reg == LHS_WR && wr_act) begin
				wr_data_reg <= dat_s;
			end
		end
	end

	// read holder: refilled after each data read, so the first read is a dummy
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			rd_hold_reg <= '0;
			mem_rd_req_reg <= 1'b0;
		end else begin
			mem_rd_req_reg <= rd_end & cyc_a0_reg;
			if (state_reg == LHS_FETCH) begin
				rd_hold_reg <= MEM_RDATA;
			end
		end
	end

	// write holder: a new data byte pushes the previous one into memory
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			wr_hold_reg <= '0;
			wr_hold_vld_reg <= 1'b0;
			mem_we_reg <= 1'b0;
			mem_wdata_reg <= '0;
		end else begin
			mem_we_reg <= data_wr_evt & wr_hold_vld_reg;
			if (data_wr_evt) begin
				mem_wdata_reg <= wr_hold_reg;
				wr_hold_reg <= data_wr_val;
				wr_hold_vld_reg <= 1'b1;
			end
		end
	end

	// instruction and serial byte strobes, one cycle each
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			instr_stb_reg <= 1'b0;
			instr_data_reg <= '0;
			instr_err_reg <= 1'b0;
			ser_stb_reg <= 1'b0;
			ser_is_data_reg <= 1'b0;
		end else begin
			instr_stb_reg <= instr_evt;
			instr_err_reg <= ser_cut;
			if (instr_evt) begin
				instr_data_reg <= instr_val;
			end
			ser_stb_reg <= ser_new;
			if (ser_new) begin
				ser_is_data_reg <= sif.is_data;
			end
		end
	end

	// edge history for the crossings and select
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			tog_prev_reg <= 1'b0;
			part_late_reg <= 1'b0;
			cs_prev_reg <= 1'b1;
		end else begin
			tog_prev_reg <= tog_s;
			part_late_reg <= part_s;
			cs_prev_reg <= cs_n_s;
		end
	end

	// drive only during a parallel read; serial mode never drives
	assign D_OE = {DW{(state_reg == LHS_RD) & bus_live}};
	assign D_OUT = dout_reg;
	assign INSTR_STB = instr_stb_reg;
	assign INSTR_DATA = instr_data_reg;
	assign INSTR_ERR = instr_err_reg;
	assign MEM_WE = mem_we_reg;
	assign MEM_WDATA = mem_wdata_reg;
	assign MEM_RD_REQ = mem_rd_req_reg;
	assign SER_BYTE_STB = ser_stb_reg;
	assign SER_BYTE_IS_DATA = ser_is_data_reg;
endmodule

// >>> lhs_host_if_chk.sv
`timescale 1ns/10ps
module lhs_host_if_chk import lhs_pkg::*; #(
	parameter int DW = LHS_DW
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic RSTN,
	// host side pins
	input wire logic PAR_SER_SEL,
	input wire logic CS_N,
	input wire logic [DW-1:0] D_OE,
	// core side strobes
	input wire logic INSTR_STB,
	input wire logic INSTR_ERR,
	input wire logic MEM_WE,
	input wire logic MEM_RD_REQ,
	input wire logic SER_BYTE_STB,
	input wire logic SER_BYTE_IS_DATA
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RSTN);

	// pins pass two flops, hence the settle counts
	chk_serial_no_drive: assert property ((!PAR_SER_SEL) [*5] |-> D_OE == '0)
		else $error("data pins driven in serial mode");
	chk_desel_float: assert property (CS_N [*5] |-> D_OE == '0)
		else $error("data pins driven while deselected");
	chk_fetch_after_read: assert property (MEM_RD_REQ |-> D_OE == '0 && $past(D_OE) == '1)
		else $error("memory fetch not at end of a read");
	chk_err_with_instr: assert property (INSTR_ERR |-> INSTR_STB)
		else $error("cut byte flag without instruction");
	chk_instr_single: assert property (INSTR_STB |=> !INSTR_STB)
		else $error("instruction strobe longer than one cycle");
	chk_ser_route: assert property (SER_BYTE_STB |-> INSTR_STB == !SER_BYTE_IS_DATA)
		else $error("serial byte routed against its tag");
	chk_ser_whole: assert property (SER_BYTE_STB |-> !INSTR_ERR)
		else $error("whole serial byte flagged as cut");
	chk_ser_pulse: assert property (SER_BYTE_STB |=> !SER_BYTE_STB)
		else $error("serial byte strobe longer than one cycle");
	chk_mem_we_alone: assert property (MEM_WE |-> !INSTR_STB && !MEM_RD_REQ)
		else $error("memory commit collides with other strobe");
	chk_desel_no_byte: assert property (CS_N [*6] |-> !SER_BYTE_STB)
		else $error("serial byte while deselected");
	// reset acts on its own, so this one is never disabled
	chk_reset_quiet: assert property (disable iff (1'b0) !RSTN |-> D_OE == '0 && !MEM_WE && !INSTR_STB)
		else $error("outputs active during reset");
endmodule

// >>> lhs_host_model.sv
`timescale 1ns/10ps
module lhs_host_model import lhs_pkg::*; (
	// main clock paces parallel cycles
	input wire logic mclk,
	// host pins
	output logic ser_clk,
	output logic cs_n,
	output logic cmd_data,
	output logic rd_n,
	output logic wr_n,
	output logic [7:0] d_in,
	input wire logic [7:0] d_out,
	input wire logic [7:0] d_oe
);
	logic [7:0] q;
	initial begin
		ser_clk = 1'b0;
		cs_n = 1'b1;
		cmd_data = 1'b0;
		rd_n = 1'b1;
		wr_n = 1'b1;
		d_in = 8'h00;
	end
	// n bits msb first; clock runs only inside the frame
	task automatic ser(input logic [7:0] b, input logic a0, input int n, input logic sel);
		cs_n = !sel;
		cmd_data = a0;
		#13;
		for (int i = 7; i > 7 - n; i--) begin
			d_in[7] = b[i];
			#7.5 ser_clk = 1'b1;
			#7.5 ser_clk = 1'b0;
		end
		d_in = ~d_in;
	endtask
	// deselect, then keep the instruction gap
	task automatic desel();
		#20 cs_n = 1'b1;
		#(LHS_SER_GAP_NS + 10);
	endtask
	// 80 or 68 style cycle, strobe held past the sync delay
	task automatic par(input logic rd, input logic a0, input logic [7:0] d, input logic s68);
		@(negedge mclk);
		cs_n = 1'b0;
		cmd_data = a0;
		d_in = d;
		rd_n = s68 | !rd;
		wr_n = rd;
		repeat (6) @(negedge mclk);
		// an undriven bus reads back inverted, so a floating pin cannot pass
		q = d_out ^ ~d_oe;
		rd_n = !s68;
		wr_n = 1'b1;
		d_in = ~d;
		// idle cycles instead of a stretched strobe
		repeat (6) @(negedge mclk);
		cs_n = 1'b1;
	endtask
endmodule

// >>> tb_lhs_host_if.sv
`timescale 1ns/10ps
module tb_lhs_host_if;
	import lhs_pkg::*;
	logic mclk = 1'b0;
	logic rstn = 1'b1;
	logic par_ser = 1'b0;
	logic style = 1'b0;
	logic [7:0] mem_rdata = 8'h00;
	logic [7:0] status = 8'h00;
	logic ser_clk, cs_n, cmd_data, rd_n, wr_n;
	logic [7:0] d_in, d_out, d_oe, instr_data, mem_wdata;
	logic instr_stb, instr_err, mem_we, mem_rd_req, ser_stb, ser_tag;
	logic [7:0] ev = 8'h00, i_n = 8'h00, m_n = 8'h00, r_n = 8'h00, i_d, m_d;
	logic i_e, s_t;
	int fail_count = 0;
	int samples_checked = 0;
	// 50 MHz main clock
	always #10 mclk = ~mclk;
	lhs_host_if uut (.MCLK(mclk), .RSTN(rstn), .SER_CLK(ser_clk), .PAR_SER_SEL(par_ser),
		.BUS_STYLE_SELECT(style), .CS_N(cs_n), .CMD_DATA_SELECT(cmd_data), .RD_N(rd_n),
		.WR_N(wr_n), .D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe), .INSTR_STB(instr_stb),
		.INSTR_DATA(instr_data), .INSTR_ERR(instr_err), .MEM_WE(mem_we),
		.MEM_WDATA(mem_wdata), .MEM_RD_REQ(mem_rd_req), .MEM_RDATA(mem_rdata),
		.STATUS_IN(status), .SER_BYTE_STB(ser_stb), .SER_BYTE_IS_DATA(ser_tag));
	lhs_host_model host (.mclk(mclk), .ser_clk(ser_clk), .cs_n(cs_n), .cmd_data(cmd_data),
		.rd_n(rd_n), .wr_n(wr_n), .d_in(d_in), .d_out(d_out), .d_oe(d_oe));
	// log every pulse; single-cycle strobes would be missed otherwise
	always @(posedge mclk) begin
		if (instr_stb) begin
			i_n <= i_n + 8'h01;
			i_d <= instr_data;
			i_e <= instr_err;
		end
		if (mem_we) begin
			m_n <= m_n + 8'h01;
			m_d <= mem_wdata;
		end
		if (ser_stb)
			s_t <= ser_tag;
		if (mem_rd_req)
			r_n <= r_n + 8'h01;
		if (instr_stb || mem_we || ser_stb)
			ev <= ev + 8'h01;
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wait_ev(input logic [7:0] e0);
		for (int k = 0; k < 30 && ev === e0; k++)
			@(negedge mclk);
		repeat (3) @(negedge mclk);
	endtask
	task automatic stop_test();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic t_ser_instr();
		host.ser(8'h96, 1'b0, 8, 1'b1);
		wait_ev(8'h00);
		host.desel();
		check(i_n, 8'h01);
		check(i_d, 8'h96);
		check(i_e, 1'b0);
		check(s_t, 1'b0);
		$display("serial instruction done");
	endtask
	// back to back data bytes; the second commits the first
	task automatic t_ser_data();
		logic [7:0] e0;
		e0 = ev;
		host.ser(8'h3a, 1'b1, 8, 1'b1);
		wait_ev(e0);
		host.ser(8'hc5, 1'b1, 8, 1'b1);
		wait_ev(e0 + 8'h01);
		host.desel();
		check(m_n, 8'h01);
		check(m_d, 8'h3a);
		check(s_t, 1'b1);
		$display("serial data done");
	endtask
	task automatic t_ser_cut();
		logic [7:0] e0;
		host.ser(8'hb0, 1'b0, 3, 1'b1);
		host.desel();
		check(i_n, 8'h02);
		check(i_e, 1'b1);
		check(i_d, 8'h05);
		e0 = ev;
		host.ser(8'h42, 1'b0, 8, 1'b1);
		wait_ev(e0);
		host.desel();
		check(i_d, 8'h42);
		check(i_e, 1'b0);
		$display("cut byte done");
	endtask
	task automatic t_desel();
		logic [7:0] e0;
		e0 = ev;
		host.ser(8'hff, 1'b0, 8, 1'b0);
		repeat (10) @(negedge mclk);
		check(ev, e0);
		$display("deselected clocks done");
	endtask
	// parallel write, status read, dummy read then real read
	task automatic t_par();
		@(negedge mclk);
		par_ser = 1'b1;
		status = 8'h3c;
		mem_rdata = 8'h6e;
		repeat (4) @(negedge mclk);
		host.par(1'b0, 1'b0, 8'h5a, 1'b0);
		check(i_d, 8'h5a);
		host.par(1'b1, 1'b0, 8'h00, 1'b0);
		check(host.q, 8'h3c);
		host.par(1'b1, 1'b1, 8'h00, 1'b0);
		check(r_n, 8'h01);
		host.par(1'b1, 1'b1, 8'h00, 1'b0);
		check(host.q, 8'h6e);
		$display("parallel done");
	endtask
	// 68 style: enable on the read pin, read/write level on the write pin
	task automatic t_par68();
		@(negedge mclk);
		style = 1'b1;
		status = 8'h81;
		repeat (4) @(negedge mclk);
		host.par(1'b0, 1'b0, 8'ha5, 1'b1);
		check(i_d, 8'ha5);
		host.par(1'b0, 1'b1, 8'h77, 1'b1);
		check(m_n, 8'h02);
		check(m_d, 8'hc5);
		host.par(1'b1, 1'b0, 8'h00, 1'b1);
		check(host.q, 8'h81);
		$display("parallel 68 style done");
	endtask
	initial begin
		// a real falling edge, so the async reset acts before the first clock
		#1;
		rstn = 1'b0;
		repeat (8) @(negedge mclk);
		rstn = 1'b1;
		repeat (4) @(negedge mclk);
		t_ser_instr();
		t_ser_data();
		t_ser_cut();
		t_desel();
		t_par();
		t_par68();
		stop_test();
	end
	// watchdog well past the expected few hundred cycles
	initial begin
		#100000;
		fail_count++;
		stop_test();
	end
endmodule
bind lhs_host_if lhs_host_if_chk #(.DW(DW)) chk (.MCLK(MCLK), .RSTN(RSTN),
	.PAR_SER_SEL(PAR_SER_SEL), .CS_N(CS_N), .D_OE(D_OE), .INSTR_STB(INSTR_STB),
	.INSTR_ERR(INSTR_ERR), .MEM_WE(MEM_WE), .MEM_RD_REQ(MEM_RD_REQ),
	.SER_BYTE_STB(SER_BYTE_STB), .SER_BYTE_IS_DATA(SER_BYTE_IS_DATA));
